// *** wdr_pkg.sv ***
/*
 * Constants for the wake-up / watchdog / reset supervisor: clock rate,
 * timing coefficients per ohm of the timing resistor, derived cycle
 * counts, reset values and the state encoding.
 * Assumes a single 100 MHz block clock; timing resistor chosen at build.
 */
// How it works
// - The wake-up output is a square wave, high for the first half of each period until an edge is accepted, low for the rest.
// - Period, reset delay and reset-high-to-wake-up delay all scale from one timing resistance.
// - Only falling watchdog edges count, and the controller must give one every period.
// - An accepted watchdog edge drives the wake-up output low for the rest of its period.
// - Further watchdog edges in the same period are ignored.
// - A period without a watchdog edge ends in an active-low reset pulse.
// - At power-up reset stays low until the output is in regulation.
// - On undervoltage reset goes low and releases one reset delay after recovery.
// - A low control supply forces reset low whatever the output does.
// - The wake-up output is low whenever reset is low.
// - After reset release the wake-up cycle restarts after the high-to-wake-up delay.
// - Enable high turns the pass element on, enable low shuts it off.
package wdr_pkg;

    // block clock
    localparam real CLK_HZ = 100.0e6;

    // timing resistor and per-ohm coefficients, in seconds per ohm
    localparam real RDELAY_OHM          = 60000.0;
    localparam real WAKE_S_PER_OHM      = 4.17e-7;
    localparam real RST_DLY_S_PER_OHM   = 5.21e-8;
    localparam real WAKE_DLY_S_PER_OHM  = 2.08e-7;

    // derived cycle counts, at the default resistor value
    localparam int unsigned WAKE_PERIOD_CYC =
        int'(WAKE_S_PER_OHM * RDELAY_OHM * CLK_HZ);
    localparam int unsigned RST_DLY_CYC =
        int'(RST_DLY_S_PER_OHM * RDELAY_OHM * CLK_HZ);
    localparam int unsigned WAKE_DLY_CYC =
        int'(WAKE_DLY_S_PER_OHM * RDELAY_OHM * CLK_HZ);

    // counter width, enough for several seconds at 100 MHz
    localparam int CNT_W = 32;

    // values after reset
    localparam logic RST_N_INIT = 1'b0;
    localparam logic WAKE_INIT  = 1'b0;
    localparam logic PASS_INIT  = 1'b0;

    // reset cause codes
    localparam logic [2:0] CAUSE_NONE  = 3'h0;
    localparam logic [2:0] CAUSE_REG   = 3'h1;
    localparam logic [2:0] CAUSE_SUPP  = 3'h2;
    localparam logic [2:0] CAUSE_WDOG  = 3'h4;

    // supervisor states, one-hot
    typedef enum logic [3:0] {
        ST_HOLD  = 4'b0001,
        ST_RDLY  = 4'b0010,
        ST_WDLY  = 4'b0100,
        ST_RUN   = 4'b1000
    } sup_state_t;

endpackage

// *** wdi_carrier_if.sv ***
/*
 * Carrier between the watchdog edge detector and the supervisor:
 * synchronised level and a one-cycle falling-edge pulse.
 * Assumes both ends sit in the core_clk domain.
 */
`timescale 1ns/1ps
interface wdi_carrier_if;
    logic level;
    logic fall;

    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface

// *** wdi_edge_detect.sv ***
/*
 * Watchdog input conditioner: two-stage synchroniser and falling-edge
 * detector working on the second stage only.
 * Assumes watchdog_input may come from another clock or a slow pin.
 */
`timescale 1ns/1ps
module wdi_edge_detect (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // raw watchdog pin
    input  wire logic watchdog_input,
    // conditioned outputs
    wdi_carrier_if.src car
);
    logic sync_a;
    logic sync_b;
    logic prev_b;
    logic fall_q;
    logic next_fall;

    // edge found only between synced samples, never on sync_a
    always_comb begin
        next_fall = prev_b & ~sync_b;
    end

    // synchroniser starts high so a low pin at release reads as one falling edge
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            prev_b <= 1'b1;
            fall_q <= 1'b0;
        end else begin
            sync_a <= watchdog_input;
            sync_b <= sync_a;
            prev_b <= sync_b;
            fall_q <= next_fall;
        end
    end

    assign car.level = prev_b;
    assign car.fall  = fall_q;
endmodule

// *** wakeup_watchdog_reset_supervisor.sv ***
/*
 * Supervisor top: power-good reset with delay, control-supply reset,
 * wake-up square wave generator and watchdog window check.
 * Assumes all status inputs are synchronous to core_clk and that the
 * analog regulation itself sits outside this block.
 */
`timescale 1ns/1ps
module wakeup_watchdog_reset_supervisor #(
    parameter int unsigned WAKE_PERIOD_CYC = wdr_pkg::WAKE_PERIOD_CYC,
    parameter int unsigned RST_DLY_CYC     = wdr_pkg::RST_DLY_CYC,
    parameter int unsigned WAKE_DLY_CYC    = wdr_pkg::WAKE_DLY_CYC
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // regulator status
    input  wire logic       out_in_regulation,
    input  wire logic       supply_low,
    input  wire logic       enable,
    // controller link
    input  wire logic       watchdog_input,
    output logic            wakeup,
    output logic            reset_n,
    // regulator control and status
    output logic            pass_on,
    output logic [2:0]      reset_cause,
    output logic            watchdog_miss
);
    localparam int CW = wdr_pkg::CNT_W;

    // cycle counts at counter width, never below one cycle
    localparam logic [CW-1:0] PERIOD_N =
        (WAKE_PERIOD_CYC < 2) ? CW'(2) : CW'(WAKE_PERIOD_CYC);
    localparam logic [CW-1:0] HALF_N = CW'(PERIOD_N >> 1);
    localparam logic [CW-1:0] RDLY_N =
        (RST_DLY_CYC < 1) ? CW'(1) : CW'(RST_DLY_CYC);
    localparam logic [CW-1:0] WDLY_N =
        (WAKE_DLY_CYC < 1) ? CW'(1) : CW'(WAKE_DLY_CYC);

    wdi_carrier_if wdi ();

    // conditioned watchdog input
    wdi_edge_detect u_wdi (
        .core_clk       (core_clk),
        .srst           (srst),
        .watchdog_input (watchdog_input),
        .car            (wdi.src)
    );

    wdr_pkg::sup_state_t state;
    wdr_pkg::sup_state_t next_state;
    logic [CW-1:0]       cnt;
    logic [CW-1:0]       next_cnt;
    logic                accepted;
    logic                next_accepted;
    logic                next_reset_n;
    logic                next_wakeup;
    logic                next_pass_on;
    logic [2:0]          next_reset_cause;
    logic                next_watchdog_miss;
    logic                reg_bad;
    logic                last_cycle;
    logic                edge_ok;

    // reset conditions that hold reset low while present
    assign reg_bad    = ~out_in_regulation | supply_low;
    assign last_cycle = (cnt == PERIOD_N - CW'(1));
    // first falling edge of the period wins, later ones drop out
    assign edge_ok    = wdi.fall & ~accepted;

    // supervisor next-state logic
    always_comb begin
        next_state         = state;
        next_cnt           = cnt;
        next_accepted      = accepted;
        next_reset_cause   = reset_cause;
        next_watchdog_miss = 1'b0;
        case (state)
            wdr_pkg::ST_HOLD: begin
                // stays here until regulation and supply are good
                next_cnt      = '0;
                next_accepted = 1'b0;
                if (!reg_bad) begin
                    next_state = wdr_pkg::ST_RDLY;
                end
            end
            wdr_pkg::ST_RDLY: begin
                // full reset delay after recovery or after a miss
                next_accepted = 1'b0;
                if (cnt >= RDLY_N - CW'(1)) begin
                    next_cnt   = '0;
                    next_state = wdr_pkg::ST_WDLY;
                end else begin
                    next_cnt = cnt + CW'(1);
                end
            end
            wdr_pkg::ST_WDLY: begin
                // reset high, wake-up low, waiting for first rise
                next_accepted = 1'b0;
                if (cnt >= WDLY_N - CW'(1)) begin
                    next_cnt   = '0;
                    next_state = wdr_pkg::ST_RUN;
                end else begin
                    next_cnt = cnt + CW'(1);
                end
            end
            wdr_pkg::ST_RUN: begin
                // one wake-up period per pass of the counter
                if (edge_ok) begin
                    next_accepted = 1'b1;
                end
                if (last_cycle) begin
                    next_cnt      = '0;
                    next_accepted = 1'b0;
                    if (!accepted && !edge_ok) begin
                        // missed window: reset pulse of one delay
                        next_state         = wdr_pkg::ST_RDLY;
                        next_reset_cause   = wdr_pkg::CAUSE_WDOG;
                        next_watchdog_miss = 1'b1;
                    end
                end else begin
                    next_cnt = cnt + CW'(1);
                end
            end
            default: begin
                next_state    = wdr_pkg::ST_HOLD;
                next_cnt      = '0;
                next_accepted = 1'b0;
            end
        endcase
        // supply and regulation faults override everything
        if (reg_bad) begin
            next_state         = wdr_pkg::ST_HOLD;
            next_cnt           = '0;
            next_accepted      = 1'b0;
            next_watchdog_miss = 1'b0;
            next_reset_cause   = supply_low ? wdr_pkg::CAUSE_SUPP
                                            : wdr_pkg::CAUSE_REG;
        end
    end

    // output next values, taken from the next state except pass_on, which follows enable
    always_comb begin
        // reset high only in the delay-to-wake and run states
        next_reset_n = (next_state == wdr_pkg::ST_WDLY) ||
                       (next_state == wdr_pkg::ST_RUN);
        // high half of the period unless already answered
        next_wakeup  = (next_state == wdr_pkg::ST_RUN) &&
                       (next_cnt < HALF_N) &&
                       !next_accepted;
        // pass element follows enable directly
        next_pass_on = enable;
    end

    // registers; outputs come straight from these flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state         <= wdr_pkg::ST_HOLD;
            cnt           <= '0;
            accepted      <= 1'b0;
            reset_n       <= wdr_pkg::RST_N_INIT;
            wakeup        <= wdr_pkg::WAKE_INIT;
            pass_on       <= wdr_pkg::PASS_INIT;
            reset_cause   <= wdr_pkg::CAUSE_REG;
            watchdog_miss <= 1'b0;
        end else begin
            state         <= next_state;
            cnt           <= next_cnt;
            accepted      <= next_accepted;
            reset_n       <= next_reset_n;
            wakeup        <= next_wakeup;
            pass_on       <= next_pass_on;
            reset_cause   <= next_reset_cause;
            watchdog_miss <= next_watchdog_miss;
        end
    end
endmodule

// *** wdr_checker.sv ***
/* checker on the supervisor top ports, bound into the design
 * assumes one clock domain and synchronous srst */
`timescale 1ns/1ps
module wdr_checker #(
    parameter int unsigned WAKE_PERIOD_CYC = 40,
    parameter int unsigned RST_DLY_CYC     = 5,
    parameter int unsigned WAKE_DLY_CYC    = 10
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       srst,
    // inputs
    input wire logic       out_in_regulation,
    input wire logic       supply_low,
    input wire logic       enable,
    input wire logic       watchdog_input,
    // outputs
    input wire logic       wakeup,
    input wire logic       reset_n,
    input wire logic       pass_on,
    input wire logic [2:0] reset_cause,
    input wire logic       watchdog_miss
);
    logic [31:0] hi_cnt, next_hi_cnt, ok_cnt, next_ok_cnt;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // run lengths; not reset so a long good supply is still seen
    always_comb begin
        next_hi_cnt = wakeup ? hi_cnt + 32'h0000_0001 : '0;
        next_ok_cnt = (out_in_regulation && !supply_low) ?
                      ok_cnt + 32'h0000_0001 : '0;
    end
    always_ff @(posedge core_clk) begin
        hi_cnt <= next_hi_cnt;
        ok_cnt <= next_ok_cnt;
    end
    a_supply_low_reset: assert property (supply_low |=> !reset_n)
        else $error("reset_n high after supply low");
    a_reg_bad_reset: assert property (!out_in_regulation |=> !reset_n)
        else $error("reset_n high while out of regulation");
    a_wake_in_reset: assert property (!reset_n |-> !wakeup)
        else $error("wakeup high during reset");
    a_half_duty: assert property (hi_cnt <= WAKE_PERIOD_CYC / 2)
        else $error("wakeup high too long");
    a_release_delay: assert property ($rose(reset_n) |-> ok_cnt >= RST_DLY_CYC)
        else $error("reset released early");
    a_miss_resets: assert property (watchdog_miss |-> ##[0:1] (!reset_n && reset_cause == 3'h4))
        else $error("missed watchdog without reset");
    a_restart_delay: assert property ($rose(reset_n) |-> !wakeup [*8])
        else $error("wakeup too soon after release");
    a_edge_accept: assert property ($fell(watchdog_input) && wakeup |-> ##[1:5] !wakeup)
        else $error("watchdog edge not accepted");
    a_pass_follow: assert property (!srst && !$past(srst) |=> pass_on == $past(enable))
        else $error("pass_on not following enable");
    c_miss: cover property (watchdog_miss);
    c_accept: cover property ($fell(wakeup) && reset_n);
    c_release: cover property ($rose(reset_n));
endmodule
bind wakeup_watchdog_reset_supervisor wdr_checker #(
    .WAKE_PERIOD_CYC(WAKE_PERIOD_CYC), .RST_DLY_CYC(RST_DLY_CYC),
    .WAKE_DLY_CYC(WAKE_DLY_CYC)) u_chk (.core_clk(core_clk), .srst(srst),
    .out_in_regulation(out_in_regulation), .supply_low(supply_low),
    .enable(enable), .watchdog_input(watchdog_input), .wakeup(wakeup),
    .reset_n(reset_n), .pass_on(pass_on), .reset_cause(reset_cause),
    .watchdog_miss(watchdog_miss));

// *** wake_answer_model.sv ***
/* controller model: answers wake-up rises with watchdog pulses
 * assumes mode and delay are set by the bench between rises */
`timescale 1ns/1ps
module wake_answer_model (
    // clock and wake-up from the supervisor
    input  wire logic       core_clk,
    input  wire logic       wakeup,
    // 0 answer, 1 silent, 2 two pulses
    input  wire logic [1:0] mode,
    input  wire logic [7:0] delay,
    // watchdog pin
    output logic            watchdog_input
);
    logic [1:0] m;
    // idle high so a quiet pin never reads as an edge
    initial watchdog_input = 1'b1;
    task automatic pulse();
        watchdog_input <= 1'b0;
        repeat (3) @(posedge core_clk);
        watchdog_input <= 1'b1;
    endtask
    // mode latched at the rise: the bench may change it mid-answer
    always @(posedge wakeup) begin
        m = mode;
        if (m != 2'd1) begin
            repeat (delay) @(posedge core_clk);
            pulse();
            if (m == 2'd2) begin
                repeat (4) @(posedge core_clk);
                pulse();
            end
        end
    end
endmodule

// *** wakeup_watchdog_reset_supervisor_tb.sv ***
/* bench for the supervisor with short timing and a controller model
 * assumes package, interface and design files compiled first */
`timescale 1ns/1ps
module wakeup_watchdog_reset_supervisor_tb;
    localparam int P = 40;
    localparam int R = 5;
    localparam int W = 10;
    logic core_clk = 0, srst = 1, out_in_regulation = 0, supply_low = 0;
    logic enable = 1, watchdog_input, wakeup, reset_n, pass_on;
    logic watchdog_miss;
    logic [2:0] reset_cause;
    logic [1:0] mode = 2'd0;
    logic [7:0] delay = 8'd30;
    int err_total = 0, checked = 0, n;
    always #5 core_clk = ~core_clk;
    wakeup_watchdog_reset_supervisor #(.WAKE_PERIOD_CYC(P),
        .RST_DLY_CYC(R), .WAKE_DLY_CYC(W)) DUT (.core_clk(core_clk),
        .srst(srst), .out_in_regulation(out_in_regulation),
        .supply_low(supply_low), .enable(enable),
        .watchdog_input(watchdog_input), .wakeup(wakeup),
        .reset_n(reset_n), .pass_on(pass_on), .reset_cause(reset_cause),
        .watchdog_miss(watchdog_miss));
    wake_answer_model ctrl (.core_clk(core_clk), .wakeup(wakeup),
        .mode(mode), .delay(delay), .watchdog_input(watchdog_input));
    task automatic complete_run();
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [2:0] exp,
                         input logic [2:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    // bounded wait; sel 0 wakeup, 1 reset_n, 2 watchdog_miss
    task automatic wait_sig(input int sel, input logic lvl, output int cnt);
        logic v;
        cnt = 0;
        do begin
            @(posedge core_clk);
            #1;
            cnt++;
            v = (sel == 0) ? wakeup : (sel == 1) ? reset_n : watchdog_miss;
            if (cnt > 300) begin
                err_total++;
                complete_run();
            end
        end while (v !== lvl);
    endtask
    task automatic power_up();
        repeat (20) @(posedge core_clk);
        #1;
        check("reset_n", 0, reset_n);
        @(posedge core_clk) out_in_regulation <= 1'b1;
        wait_sig(1, 1'b1, n);
        check("release", 1, n == R + 1);
        wait_sig(0, 1'b1, n);
        check("wake_delay", 1, n == W);
    endtask
    task automatic duty(input int d);
        int hi;
        delay = 8'(d);
        wait_sig(0, 1'b0, n);
        wait_sig(0, 1'b1, n);
        wait_sig(0, 1'b0, hi);
        wait_sig(0, 1'b1, n);
        check("period", 1, hi + n == P);
        if (d > P / 2) check("high", 1, hi == P / 2);
        else check("accept", 1, hi <= d + 6);
        check("reset_n", 1, reset_n);
    endtask
    // supply low (1) or undervoltage (0) while wakeup is high
    task automatic brownout(input logic supp);
        @(posedge core_clk) begin
            supply_low <= supp;
            out_in_regulation <= supp;
        end
        repeat (2) @(posedge core_clk);
        #1;
        check("reset_n", 0, reset_n);
        check("wakeup", 0, wakeup);
        check("cause", supp ? 3'h2 : 3'h1, reset_cause);
        @(posedge core_clk) begin
            supply_low <= 1'b0;
            out_in_regulation <= 1'b1;
        end
        wait_sig(1, 1'b1, n);
        check("release", 1, n == R + 1);
    endtask
    // two pulses in one period, then silence: the next period must miss
    task automatic miss();
        mode = 2'd2;
        delay = 8'd2;
        wait_sig(0, 1'b0, n);
        wait_sig(0, 1'b1, n);
        mode = 2'd1;
        wait_sig(2, 1'b1, n);
        check("miss_time", 1, n >= 2 * P - 2 && n <= 2 * P + 2);
        wait_sig(1, 1'b0, n);
        check("cause", 3'h4, reset_cause);
        check("wakeup", 0, wakeup);
        mode = 2'd0;
        wait_sig(1, 1'b1, n);
        check("wd_release", 1, n <= R + 1);
    endtask
    task automatic toggle_enable(input logic v);
        @(posedge core_clk) enable <= v;
        @(posedge core_clk);
        #1;
        check("pass_on", v, pass_on);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        power_up();
        duty(30);
        duty(2);
        brownout(1'b1);
        duty(2);
        brownout(1'b0);
        miss();
        toggle_enable(1'b0);
        toggle_enable(1'b1);
        complete_run();
    end
endmodule
